/* bench/test_torque_reference_filter_chain.sv */
// Testbench of the torque reference filter chain: register and sample scenarios.
// Assumes tqf_pkg, tqf_filter_chain and tqf_speed_source are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("Error %0t got %0h exp %0h", $time, g, e); end end

// ============================================================================
// Bench top.
module test_torque_reference_filter_chain;
	import tqf_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, diff, send;
	logic in_valid, in_ready, out_valid;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic signed [DATA_W-1:0] in_data, out_data, value, res;
	logic [15:0] vals [3] = '{16'h1234, 16'hC000, 16'h7FFF};
	logic [7:0] ra [3] = '{8'h00, 8'h08, 8'h2C};
	logic [31:0] rv [3] = '{32'h0000_FFFF, 32'h0000_0064, 32'h0000_01F4};
	int error_cnt, checks, lat, nsamp;

	tqf_filter_chain tqf_filter_chain_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .in_valid(in_valid), .in_data(in_data),
		.in_ready(in_ready), .out_valid(out_valid), .out_data(out_data));
	tqf_speed_source tqf_speed_source_inst (.pclk(pclk), .presetn(presetn), .send(send),
		.value(value), .in_ready(in_ready), .in_valid(in_valid), .in_data(in_data));

	// ========================================================================
	// Tasks.
	task automatic finish_test;
		$display("Mismatches %0d, comparisons %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			error_cnt++;
			finish_test();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic sample(input logic [15:0] v);
		int n;
		send <= 1'b1;
		value <= v;
		@(posedge pclk);
		send <= 1'b0;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (!(in_valid === 1'b1 && in_ready === 1'b1) && n < 40);
		lat = 0;
		do begin
			@(posedge pclk);
			lat++;
		end while (out_valid !== 1'b1 && lat < 40);
		if (n >= 40 || lat >= 40) begin
			error_cnt++;
			finish_test();
		end
		res = out_data;
		nsamp++;
	endtask : sample

	task automatic pass_all;
		for (int i = 0; i < 3; i++) begin
			sample(vals[i]);
			`CHK(res, vals[i])
			`CHK(lat, 9)
		end
	endtask : pass_all

	function automatic logic [15:0] rst_val(input int i);
		if (i < 5) return (i == 0) ? 16'h0064 : (i == 1) ? 16'h1388 : (i == 2) ? 16'h0032 : 16'h0000;
		return ((i - 5) % 3 == 0) ? 16'h1388 : ((i - 5) % 3 == 1) ? 16'h0046 : 16'h0000;
	endfunction : rst_val

	// ========================================================================
	// Clock and main sequence.
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, send} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		value = 16'h0000;
		error_cnt = 0;
		checks = 0;
		nsamp = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < CFG_COUNT; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0000_0000);
			`CHK(rd, {16'h0000, rst_val(i)})
		end
		apb(1'b0, 8'h58, 32'h0000_0000);
		`CHK(err, 1'b1)
		apb(1'b1, 8'h02, 32'h0000_FFFF);
		`CHK(err, 1'b1)
		apb(1'b0, 8'h00, 32'h0000_0000);
		`CHK(rd, 32'h0000_0064)
		apb(1'b1, 8'h00, 32'h0000_0000);
		pass_all();
		for (int k = 0; k < 5; k++) begin
			apb(1'b1, 8'(8'h1C + 12 * k), 32'h0000_03E8);
		end
		apb(1'b1, 8'h0C, 32'h0000_0101);
		apb(1'b1, 8'h10, 32'h0000_0111);
		pass_all();
		apb(1'b1, 8'h28, 32'h0000_FFFF);
		pass_all();
		apb(1'b1, 8'h1C, 32'h0000_0000);
		diff = 1'b0;
		for (int i = 0; i < 8; i++) begin
			sample(i[0] ? 16'hF060 : 16'h0FA0);
			diff = diff | (res !== (i[0] ? 16'hF060 : 16'h0FA0));
		end
		`CHK(diff, 1'b1)
		apb(1'b1, 8'h0C, 32'h0000_0102);
		pass_all();
		apb(1'b1, 8'h04, 32'h0000_0064);
		sample(16'h1F40);
		`CHK(res < 16'sh1F40, 1'b1)
		apb(1'b1, 8'h04, 32'h0000_1388);
		pass_all();
		apb(1'b1, 8'h00, 32'h0000_0064);
		sample(16'h0000);
		`CHK(res !== 16'h0000, 1'b1)
		apb(1'b1, 8'h50, 32'hFFFF_FFFF);
		`CHK(err, 1'b0)
		apb(1'b0, 8'h50, 32'h0000_0000);
		`CHK(rd[31:16], 16'(nsamp))
		`CHK(rd[0], 1'b0)
		apb(1'b0, 8'h54, 32'h0000_0000);
		`CHK(rd, {16'h0000, res})
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, ra[i], rv[i]);
			apb(1'b0, ra[i], 32'h0000_0000);
			`CHK(rd, rv[i])
		end
		finish_test();
	end
endmodule : test_torque_reference_filter_chain

`default_nettype wire

/* bench/tqf_speed_source.sv */
// Model of the speed loop controller that hands torque reference samples to the chain.
// Assumes tqf_pkg is compiled first and that the bench pulses send for one cycle.
`timescale 1ns/1ns
`default_nettype none

// ============================================================================
// Sample source.
module tqf_speed_source (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic send,
	input wire logic signed [tqf_pkg::DATA_W-1:0] value,
	input wire logic in_ready,
	output logic in_valid,
	output logic signed [tqf_pkg::DATA_W-1:0] in_data
);
	import tqf_pkg::*;
	// The sample is held until it is taken; afterwards the data line shows its inverse.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_valid <= 1'b0;
			in_data <= 16'h0000;
		end else if (in_valid && in_ready) begin
			in_valid <= 1'b0;
			in_data <= ~in_data;
		end else if (send && !in_valid) begin
			in_valid <= 1'b1;
			in_data <= value;
		end
	end
endmodule : tqf_speed_source

`default_nettype wire

/* verilog/tqf_filter_chain.sv */
// Torque reference filter chain: lag, second order low-pass, five notches in series.
// Assumes samples arrive on pclk with a valid strobe and that software uses APB.
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module tqf_filter_chain #(
	parameter int SAMPLE_NS = 16000,
	parameter int ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic in_valid,
	input wire logic signed [tqf_pkg::DATA_W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic signed [tqf_pkg::DATA_W-1:0] out_data
);
	import tqf_pkg::*;

	// ========================================================================
	// Derived coefficient constants.
	localparam longint F_PER_HZ_L = (longint'(SAMPLE_NS) * TWO_PI_CF) / NS_PER_S;
	localparam logic [COEF_W-1:0] F_PER_HZ = COEF_W'(F_PER_HZ_L);
	localparam logic [47:0] TS_NUM = 48'(longint'(SAMPLE_NS) <<< CF);
	localparam logic [47:0] LAG_UNIT = 48'(LAG_UNIT_NS);
	localparam logic [47:0] TS_W = 48'(SAMPLE_NS);
	localparam logic [31:0] Q_NUM = 32'(Q_SCALE) << CF;
	localparam logic [31:0] DEPTH_DEN = 32'(DEPTH_SCALE);

	// ========================================================================
	// Helper functions.
	function automatic logic signed [ST_W-1:0] mulq(
		input logic signed [ST_W-1:0] a,
		input logic [COEF_W-1:0] c
	);
		logic signed [ST_W+COEF_W:0] prod;
		prod = a * $signed({1'b0, c});
		return ST_W'(prod >>> CF);
	endfunction : mulq

	function automatic logic signed [DATA_W-1:0] sat(input logic signed [ST_W-1:0] v);
		logic signed [ST_W-1:0] s;
		logic signed [ST_W-1:0] hi;
		logic signed [ST_W-1:0] lo;
		s = v >>> SF;
		hi = ST_W'({1'b0, {(DATA_W-1){1'b1}}});
		lo = -hi - ST_W'(1);
		if (s > hi) begin
			return DATA_W'(hi);
		end else if (s < lo) begin
			return DATA_W'(lo);
		end
		return DATA_W'(s);
	endfunction : sat

	function automatic logic [IDX_W-1:0] notch_idx(input logic [2:0] n, input int field);
		return IDX_W'(IDX_NOTCH_BASE + IDX_W'(n) * IDX_W'(NOTCH_STRIDE) + IDX_W'(field));
	endfunction : notch_idx

	// ========================================================================
	// Register storage and state.
	logic [REG_W-1:0] cfg [CFG_COUNT];
	tqf_state_t state;
	tqf_state_t next_state;
	logic [2:0] nidx;
	logic signed [ST_W-1:0] acc;
	logic signed [ST_W-1:0] lag_st;
	logic signed [ST_W-1:0] lp_st [NOTCH_COUNT+1];
	logic signed [ST_W-1:0] bp_st [NOTCH_COUNT+1];
	logic [15:0] sample_cnt;

	// ========================================================================
	// APB decode.
	wire logic [IDX_W-1:0] bus_idx = paddr[IDX_W+1:2];
	wire logic bus_hit = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:2] < REG_COUNT);
	wire logic bus_setup = psel && !penable;
	wire logic bus_wr = psel && penable && pready && pwrite && bus_hit
		&& (bus_idx < IDX_W'(CFG_COUNT));
	wire logic [31:0] status_word = {sample_cnt, 15'h0000, (state != ST_IDLE)};
	wire logic [31:0] rd_val = (bus_idx < IDX_W'(CFG_COUNT)) ? {16'h0000, cfg[bus_idx]} :
		(bus_idx == IDX_STATUS) ? status_word :
		{16'h0000, out_data};

	// Registers take a new value at the write edge; the next stage to run uses it, even within a sample.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= bus_setup;
			pslverr <= bus_setup && !bus_hit;
			prdata <= (bus_setup && bus_hit) ? rd_val : 32'h00000000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg[IDX_LAG_TC] <= RST_LAG_TC;
			cfg[IDX_LP2_FREQ] <= RST_FREQ;
			cfg[IDX_LP2_Q] <= RST_LP2_Q;
			cfg[IDX_SEL_A] <= RST_SELECT;
			cfg[IDX_SEL_B] <= RST_SELECT;
			for (int n = 0; n < NOTCH_COUNT; n++) begin
				cfg[IDX_NOTCH_BASE + n * NOTCH_STRIDE] <= RST_FREQ;
				cfg[IDX_NOTCH_BASE + n * NOTCH_STRIDE + 1] <= RST_NOTCH_Q;
				cfg[IDX_NOTCH_BASE + n * NOTCH_STRIDE + 2] <= RST_NOTCH_DEPTH;
			end
		end else if (bus_wr) begin
			cfg[bus_idx] <= pwdata[REG_W-1:0];
		end
	end

	// ========================================================================
	// Parameters of the stage being worked on.
	wire logic [REG_W-1:0] n_freq = cfg[notch_idx(nidx, 0)];
	wire logic [REG_W-1:0] n_q = cfg[notch_idx(nidx, 1)];
	wire logic [REG_W-1:0] n_depth = cfg[notch_idx(nidx, 2)];
	wire logic [REG_W-1:0] sel_reg = SEL_IN_B[nidx] ? cfg[IDX_SEL_B] : cfg[IDX_SEL_A];
	wire logic [SEL_DIGIT_W-1:0] sel_digit = sel_reg[SEL_LSB[nidx] +: SEL_DIGIT_W];
	wire logic notch_on = (sel_digit == SEL_ON);
	wire logic lp2_bypass = (cfg[IDX_LP2_FREQ] >= LP2_BYPASS_HZ);
	wire logic in_lp2 = (state == ST_LP2);
	wire logic [2:0] slot = in_lp2 ? 3'd0 : 3'(nidx + 3'd1);
	wire logic [REG_W-1:0] s_freq = in_lp2 ? cfg[IDX_LP2_FREQ] : n_freq;
	wire logic [REG_W-1:0] s_q_raw = in_lp2 ? cfg[IDX_LP2_Q] : n_q;
	wire logic [REG_W-1:0] s_q = (s_q_raw < Q_MIN) ? Q_MIN : s_q_raw;
	wire logic [REG_W-1:0] s_depth = (n_depth > DEPTH_UNITY) ? DEPTH_UNITY : n_depth;

	// ========================================================================
	// Coefficients, fraction CF.
	wire logic [COEF_W-1:0] f_coef = COEF_W'(F_PER_HZ * s_freq);
	wire logic [COEF_W-1:0] q1_coef = COEF_W'(Q_NUM / {16'h0000, s_q});
	wire logic [31:0] g_num = 32'(DEPTH_UNITY - s_depth) << CF;
	wire logic [COEF_W-1:0] g_coef = COEF_W'(g_num / DEPTH_DEN);
	wire logic [47:0] lag_den = 48'(cfg[IDX_LAG_TC]) * LAG_UNIT + TS_W;
	wire logic [COEF_W-1:0] alpha = COEF_W'(TS_NUM / lag_den);

	// ========================================================================
	// Datapath: lag update and state variable section.
	wire logic signed [ST_W-1:0] lag_n = lag_st + mulq(acc - lag_st, alpha);
	wire logic signed [ST_W-1:0] s_lp = lp_st[slot];
	wire logic signed [ST_W-1:0] s_bp = bp_st[slot];
	wire logic signed [ST_W-1:0] hp = acc - s_lp - mulq(s_bp, q1_coef);
	wire logic signed [ST_W-1:0] bp_n = s_bp + mulq(hp, f_coef);
	wire logic signed [ST_W-1:0] lp_n = s_lp + mulq(bp_n, f_coef);
	// Band reject part is x minus the band output; depth scales how much is removed.
	wire logic signed [ST_W-1:0] notch_n = acc - mulq(acc - hp - s_lp, g_coef);
	wire logic svf_upd = (in_lp2 && !lp2_bypass) || (state == ST_NOTCH && notch_on);
	wire logic accept = (state == ST_IDLE) && in_valid && in_ready;

	// ========================================================================
	// Sequencer: one stage per cycle in series.
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (accept) begin
					next_state = ST_LAG;
				end
			end
			ST_LAG: begin
				next_state = ST_LP2;
			end
			ST_LP2: begin
				next_state = ST_NOTCH;
			end
			ST_NOTCH: begin
				if (nidx == 3'(NOTCH_COUNT - 1)) begin
					next_state = ST_DONE;
				end
			end
			ST_DONE: begin
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
			nidx <= 3'd0;
			in_ready <= 1'b0;
		end else begin
			state <= next_state;
			nidx <= (state == ST_NOTCH && next_state == ST_NOTCH) ? 3'(nidx + 3'd1) : 3'd0;
			in_ready <= (next_state == ST_IDLE);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc <= '0;
			lag_st <= '0;
		end else if (accept) begin
			acc <= ST_W'(in_data) <<< SF;
		end else if (state == ST_LAG) begin
			acc <= lag_n;
			lag_st <= lag_n;
		end else if (in_lp2 && !lp2_bypass) begin
			acc <= lp_n;
		end else if (state == ST_NOTCH && notch_on) begin
			acc <= notch_n;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int s = 0; s <= NOTCH_COUNT; s++) begin
				lp_st[s] <= '0;
				bp_st[s] <= '0;
			end
		end else if (svf_upd) begin
			lp_st[slot] <= lp_n;
			bp_st[slot] <= bp_n;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_valid <= 1'b0;
			out_data <= '0;
			sample_cnt <= 16'h0000;
		end else begin
			out_valid <= (state == ST_DONE);
			if (state == ST_DONE) begin
				out_data <= sat(acc);
				sample_cnt <= 16'(sample_cnt + 16'h0001);
			end
		end
	end

	// ========================================================================
	// Assertions.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_accept;
		accept;
	endsequence

	sequence s_busy;
		!in_ready [*8];
	endsequence

	sequence s_notch_walk;
		state == ST_NOTCH [*5];
	endsequence

	chk_lag_write_now: assert property (
		bus_wr && bus_idx == IDX_LAG_TC |=> cfg[IDX_LAG_TC] == $past(pwdata[REG_W-1:0]))
		else $error("lag time constant not stored");

	chk_lag_zero_pass: assert property (
		state == ST_LAG && cfg[IDX_LAG_TC] == 16'h0000 |=> acc == $past(acc))
		else $error("zero lag time constant changed the sample");

	chk_lp2_bypass_hold: assert property (
		in_lp2 && cfg[IDX_LP2_FREQ] == LP2_BYPASS_HZ |=> acc == $past(acc) && $stable(lp_st[0]))
		else $error("low-pass at maximum cutoff altered the sample");

	chk_lp2_q_store: assert property (
		bus_wr && bus_idx == IDX_LP2_Q |=> cfg[IDX_LP2_Q] == $past(pwdata[REG_W-1:0]))
		else $error("low-pass Q not stored");

	chk_notch_off_hold: assert property (
		state == ST_NOTCH && sel_digit != SEL_ON |=> acc == $past(acc))
		else $error("disabled notch altered the sample");

	chk_notch_b_select: assert property (
		state == ST_NOTCH && nidx >= 3'd2 && cfg[IDX_SEL_B] == RST_SELECT
		|=> acc == $past(acc))
		else $error("notch three to five ran with select B cleared");

	chk_depth_unity_pass: assert property (
		state == ST_NOTCH && notch_on && n_depth == DEPTH_UNITY |=> acc == $past(acc))
		else $error("unity depth notch attenuated the sample");

	chk_sample_latency: assert property (
		s_accept |=> s_busy ##1 out_valid && in_ready)
		else $error("sample did not finish in nine cycles");

	chk_chain_order: assert property (
		state == ST_LAG |=> in_lp2 ##1 state == ST_NOTCH && nidx == 3'd0)
		else $error("stages not run in series order");

	chk_out_pulse_once: assert property (
		out_valid |=> !out_valid)
		else $error("out_valid held longer than one cycle");

	chk_ready_one_cycle: assert property (
		pready |=> !pready)
		else $error("pready held longer than one cycle");

	chk_ready_after_setup: assert property (
		psel && !penable |=> pready)
		else $error("access phase without pready");

	chk_err_misaligned: assert property (
		psel && !penable && paddr[1:0] != 2'b00 |=> pslverr)
		else $error("misaligned access not flagged");

	chk_err_with_ready: assert property (
		pslverr |-> pready)
		else $error("pslverr outside the access phase");

	chk_lp2_freq_store: assert property (
		bus_wr && bus_idx == IDX_LP2_FREQ |=> cfg[IDX_LP2_FREQ] == $past(pwdata[REG_W-1:0]))
		else $error("low-pass cutoff not stored");

	chk_sel_a_store: assert property (
		bus_wr && bus_idx == IDX_SEL_A |=> cfg[IDX_SEL_A] == $past(pwdata[REG_W-1:0]))
		else $error("select A not stored");

	chk_sel_b_store: assert property (
		bus_wr && bus_idx == IDX_SEL_B |=> cfg[IDX_SEL_B] == $past(pwdata[REG_W-1:0]))
		else $error("select B not stored");

	chk_notch_field_store: assert property (
		bus_wr && bus_idx >= IDX_NOTCH_BASE
		|=> cfg[$past(bus_idx)] == $past(pwdata[REG_W-1:0]))
		else $error("notch setting not stored");

	chk_lag_state_follow: assert property (
		state == ST_LAG |=> lag_st == acc)
		else $error("lag state and sample differ after the lag stage");

	chk_lp2_state_follow: assert property (
		in_lp2 && !lp2_bypass |=> acc == lp_st[0])
		else $error("low-pass output not taken as the sample");

	chk_notch_state_hold: assert property (
		state == ST_NOTCH && nidx == 3'd0 && !notch_on
		|=> $stable(lp_st[1]) && $stable(bp_st[1]))
		else $error("disabled notch one changed its state");

	chk_accept_busy: assert property (
		s_accept |=> !in_ready)
		else $error("chain still ready after taking a sample");

	chk_ready_idle: assert property (
		in_ready |-> state == ST_IDLE)
		else $error("chain ready while busy");

	chk_idle_wait: assert property (
		state == ST_IDLE && !in_valid |=> state == ST_IDLE)
		else $error("chain started without a sample");

	chk_out_after_done: assert property (
		state == ST_DONE |=> out_valid)
		else $error("finished sample not presented");

	chk_out_data_hold: assert property (
		!out_valid |-> $stable(out_data))
		else $error("out_data changed without out_valid");

	chk_count_step: assert property (
		out_valid |-> sample_cnt == 16'($past(sample_cnt) + 16'h0001))
		else $error("sample count not advanced by one");

	chk_nidx_range: assert property (
		state == ST_NOTCH |-> nidx < 3'(NOTCH_COUNT))
		else $error("notch index out of range");

	chk_notch_last: assert property (
		state == ST_NOTCH && nidx == 3'(NOTCH_COUNT - 1) |=> state == ST_DONE)
		else $error("chain did not finish after the last notch");

	chk_notch_span: assert property (
		in_lp2 |=> s_notch_walk ##1 state == ST_DONE)
		else $error("notch stages did not run five in a row");

endmodule : tqf_filter_chain

`default_nettype wire

/* verilog/tqf_pkg.sv */
// Constants, register map and state encoding of the torque reference filter chain.
// Assumes a single clock domain and software access through an APB slave.
// ============================================================================
package tqf_pkg;

	// ========================================================================
	// Widths and fixed point formats.
	localparam int DATA_W = 16;
	localparam int REG_W = 16;
	localparam int SF = 16;
	localparam int CF = 20;
	localparam int COEF_W = 24;
	localparam int ST_W = DATA_W + SF + 6;
	localparam int IDX_W = 5;

	// ========================================================================
	// Register indices; byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_LAG_TC = 5'h00;
	localparam logic [IDX_W-1:0] IDX_LP2_FREQ = 5'h01;
	localparam logic [IDX_W-1:0] IDX_LP2_Q = 5'h02;
	localparam logic [IDX_W-1:0] IDX_SEL_A = 5'h03;
	localparam logic [IDX_W-1:0] IDX_SEL_B = 5'h04;
	localparam logic [IDX_W-1:0] IDX_NOTCH_BASE = 5'h05;
	localparam logic [IDX_W-1:0] IDX_STATUS = 5'h14;
	localparam logic [IDX_W-1:0] IDX_OUT = 5'h15;
	localparam int NOTCH_STRIDE = 3;
	localparam int NOTCH_COUNT = 5;
	localparam int CFG_COUNT = 20;
	localparam int REG_COUNT = 22;

	// ========================================================================
	// Reset values.
	localparam logic [REG_W-1:0] RST_LAG_TC = 16'h0064;
	localparam logic [REG_W-1:0] RST_FREQ = 16'h1388;
	localparam logic [REG_W-1:0] RST_LP2_Q = 16'h0032;
	localparam logic [REG_W-1:0] RST_SELECT = 16'h0000;
	localparam logic [REG_W-1:0] RST_NOTCH_Q = 16'h0046;
	localparam logic [REG_W-1:0] RST_NOTCH_DEPTH = 16'h0000;

	// ========================================================================
	// Setting limits and scales.
	localparam logic [REG_W-1:0] LP2_BYPASS_HZ = 16'h1388;
	localparam logic [REG_W-1:0] Q_MIN = 16'h0032;
	localparam logic [REG_W-1:0] DEPTH_UNITY = 16'h03E8;
	localparam int Q_SCALE = 100;
	localparam int DEPTH_SCALE = 1000;
	localparam int LAG_UNIT_NS = 10000;
	localparam longint TWO_PI_CF = 64'd6588397;
	localparam longint NS_PER_S = 64'd1000000000;

	// ========================================================================
	// Enable digit of each notch: selection register and low bit.
	localparam int SEL_DIGIT_W = 4;
	localparam logic [SEL_DIGIT_W-1:0] SEL_ON = 4'h1;
	localparam int SEL_LSB [NOTCH_COUNT] = '{0, 8, 0, 4, 8};
	localparam bit SEL_IN_B [NOTCH_COUNT] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
	localparam int STATUS_CNT_LSB = 16;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_LAG = 3'b001,
		ST_LP2 = 3'b010,
		ST_NOTCH = 3'b011,
		ST_DONE = 3'b100
	} tqf_state_t;

endpackage : tqf_pkg
